// >>> sbsp_burst_ctr.sv
// Address register with two-bit burst counter
`default_nettype none
`timescale 1ns/10ps
module sbsp_burst_ctr
(
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  // Control
  input  wire logic                        en_i,
  input  wire logic                        advance_i,
  input  wire logic [sbsp_pkg::ADDR_W-1:0] addr_i,
  // Current address
  output logic      [sbsp_pkg::ADDR_W-1:0] addr_o
);
  logic [sbsp_pkg::ADDR_W-1:0] base_q;
  logic [sbsp_pkg::BURST_W-1:0] cnt_q;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      base_q <= sbsp_pkg::ADDR_RST;
      cnt_q  <= sbsp_pkg::BURST_RST;
    end
    else if (en_i)
    begin
      if (advance_i)
        cnt_q <= cnt_q + 2'h1; // RULE1 RULE13
      else
      begin
        base_q <= addr_i; // RULE2
        cnt_q  <= addr_i[sbsp_pkg::BURST_W-1:0]; // RULE13
      end
    end
  end

  assign addr_o = {base_q[sbsp_pkg::ADDR_W-1:sbsp_pkg::BURST_W], cnt_q};

  chk_burst_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    en_i && advance_i |=> cnt_q == $past(cnt_q) + 2'h1) // RULE1
    else $error("burst counter did not step");
  chk_load_seed: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    en_i && !advance_i |=> addr_o == $past(addr_i)) // RULE2
    else $error("address not loaded");
endmodule
`default_nettype wire

// >>> sbsp_ctrl_model.sv
// Memory controller model facing the burst memory port
`default_nettype none
`timescale 1ns/10ps
module sbsp_ctrl_model
(
  // Clock
  input  wire logic                       mclk_i,
  // Command, sleep and data toward the port
  output var  logic                       clock_gate_n_o,
  output var  sbsp_pkg::sbsp_cmd_t        cmd_o,
  output var  logic                       sleep_request_o,
  output var  logic [sbsp_pkg::DATA_W-1:0] dq_o
);
  initial
  begin
    clock_gate_n_o  = 1'b0;
    cmd_o           = '0;
    sleep_request_o = 1'b0;
    dq_o            = 40'h0;
  end

  // One command per edge; released data lines show the inverse
  task automatic step(input logic g, s, w, a,
                      input logic [sbsp_pkg::ADDR_W-1:0] ad,
                      input logic dv, input logic [39:0] d);
    @(posedge mclk_i);
    clock_gate_n_o        <= g;
    cmd_o.select          <= s;
    cmd_o.write           <= w;
    cmd_o.advance_or_load <= a & cmd_o.select;
    cmd_o.addr            <= ad;
    dq_o                  <= dv ? d : ~dq_o;
  endtask

  // Sleep request changes only between transfers
  task automatic nap(input logic z);
    @(posedge mclk_i);
    sleep_request_o <= z;
  endtask
endmodule
`default_nettype wire

// >>> sbsp_mem.sv
// Flip-flop word storage indexed by address
`default_nettype none
`timescale 1ns/10ps
module sbsp_mem
(
  // Clock
  input  wire logic                        mclk_i,
  // Write port
  input  wire logic                        wr_i,
  input  wire logic [sbsp_pkg::IDX_W-1:0]  widx_i,
  input  wire logic [sbsp_pkg::DATA_W-1:0] wdata_i,
  // Read port
  input  wire logic [sbsp_pkg::IDX_W-1:0]  ridx_i,
  output logic      [sbsp_pkg::DATA_W-1:0] rdata_o
);
  logic [sbsp_pkg::DATA_W-1:0] mem_q [sbsp_pkg::MEM_DEPTH];

  // No reset: contents survive reset and sleep
  always_ff @(posedge mclk_i)
  begin
    if (wr_i)
      mem_q[widx_i] <= wdata_i; // RULE11
  end

  assign rdata_o = mem_q[ridx_i];
endmodule
`default_nettype wire

// >>> sbsp_pkg.sv
// Package of constants and carrier types for the burst memory port
`default_nettype none
package sbsp_pkg;
  localparam int ADDR_W    = 21;
  localparam int DATA_W    = 40;
  localparam int BURST_W   = 2;
  localparam int MEM_DEPTH = 64;
  localparam int IDX_W     = 6;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [DATA_W-1:0]  DATA_RST  = 40'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 21'h0;

  typedef enum logic [1:0] {
    SBSP_DESEL = 2'b00,
    SBSP_READ  = 2'b01,
    SBSP_WRITE = 2'b10
  } sbsp_op_t;

  typedef struct packed {
    logic              select;
    logic              write;
    logic              advance_or_load;
    logic [ADDR_W-1:0] addr;
  } sbsp_cmd_t;
endpackage
`default_nettype wire

// >>> sbsp_port.sv
// Synchronous burst memory bus port
//
// Notes on behaviour
// RULE1: Advance high on enabled edge steps the burst counter.
// RULE2: Advance low on enabled edge loads a new address.
// RULE3: Controller loads a fresh address after deselection.
// RULE4: Edges count only while the clock gate input is low.
// RULE5: Clock gate high holds and stretches the current operation.
// RULE6: Output enable low drives data lines; high floats them.
// RULE7: Data lines float in write data, after deselect, and while deselected.
// RULE8: All forty write data lines are registered at the clock edge.
// RULE9: Read data is the word of the previous edge's address.
// RULE10: Reset returns the port to a known configuration.
// RULE11: Sleep input idles the port and keeps memory contents.
// RULE12: Controller keeps sleep low in normal operation.
// RULE13: Low two address bits seed a four-word burst counter.
`default_nettype none
`timescale 1ns/10ps
module sbsp_port
(
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  // Synchronous command pins
  input  wire logic                        clock_gate_n_i,
  input  wire logic                        select_i,
  input  wire logic                        write_n_i,
  input  wire logic                        advance_or_load_i,
  input  wire logic [sbsp_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                        sleep_request_i,
  // Asynchronous output enable
  input  wire logic                        out_en_n_i,
  // Data lines
  input  wire logic [sbsp_pkg::DATA_W-1:0] dq_i,
  output logic      [sbsp_pkg::DATA_W-1:0] dq_o,
  output logic                             dq_oe_o,
  // Status
  output logic                             asleep_o
);
  sbsp_pkg::sbsp_cmd_t cmd;
  sbsp_pkg::sbsp_op_t  op_q;
  logic                          en;
  logic                          sleep_q;
  logic                          was_desel_q;
  logic                          first_q;
  logic [sbsp_pkg::ADDR_W-1:0]   cur_addr;
  logic [sbsp_pkg::DATA_W-1:0]   wdata_q;
  logic [sbsp_pkg::ADDR_W-1:0]   waddr_q;
  logic                          wpend_q;
  logic [sbsp_pkg::DATA_W-1:0]   rdata;
  logic [sbsp_pkg::DATA_W-1:0]   dq_q;
  logic                          masked;
  logic [3:0]                    stretch_q;

  function automatic logic [sbsp_pkg::IDX_W-1:0] to_idx(
    input logic [sbsp_pkg::ADDR_W-1:0] a);
    to_idx = a[sbsp_pkg::IDX_W-1:0];
  endfunction

  assign cmd.select          = select_i;
  assign cmd.write           = !write_n_i;
  assign cmd.advance_or_load = advance_or_load_i;
  assign cmd.addr            = addr_i;

  // -------------------------------------------------------------
  // Edge qualification
  // -------------------------------------------------------------
  assign en = !clock_gate_n_i && !sleep_q; // RULE4 RULE5

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sleep_q <= 1'b0;
    else
      sleep_q <= sleep_request_i; // RULE11
  end

  assign asleep_o = sleep_q;

  // Edge qualification checks
  chk_sleep_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    1'b1 |=> sleep_q == $past(sleep_request_i))
    else $error("sleep flag did not follow request");

  chk_sleep_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    sleep_q |-> !en)
    else $error("edge taken while asleep");

  chk_gate_en: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    clock_gate_n_i |-> !en)
    else $error("edge taken while clock gated");

  // -------------------------------------------------------------
  // Address and burst counter
  // -------------------------------------------------------------
  sbsp_burst_ctr u_ctr
  (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (en && cmd.select),
    .advance_i (cmd.advance_or_load && !was_desel_q),
    .addr_i    (cmd.addr),
    .addr_o    (cur_addr)
  );

  // Address checks
  chk_gate_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    !en |=> $stable(cur_addr))
    else $error("address moved on an ignored edge");

  chk_desel_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE3
    en && cmd.select && was_desel_q |=> cur_addr == $past(cmd.addr))
    else $error("no fresh load after deselect");

  chk_burst_base: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE13
    en && cmd.select && cmd.advance_or_load && !was_desel_q |=>
      $stable(cur_addr[sbsp_pkg::ADDR_W-1:sbsp_pkg::BURST_W]))
    else $error("burst advance left its four-word block");

  chk_sleep_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    sleep_q |=> $stable(cur_addr))
    else $error("address moved while asleep");

  // -------------------------------------------------------------
  // Operation state
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_q        <= sbsp_pkg::SBSP_DESEL; // RULE10
      was_desel_q <= 1'b1;
      first_q     <= 1'b0;
    end
    else if (sleep_q)
      op_q <= sbsp_pkg::SBSP_DESEL; // RULE11
    else if (en)
    begin
      first_q     <= was_desel_q && cmd.select; // RULE7
      was_desel_q <= !cmd.select;
      case ({cmd.select, cmd.write})
        2'b10:   op_q <= sbsp_pkg::SBSP_READ;
        2'b11:   op_q <= sbsp_pkg::SBSP_WRITE;
        default: op_q <= sbsp_pkg::SBSP_DESEL;
      endcase
    end
  end

  // Operation state checks
  chk_op_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    en && cmd.select && !cmd.write |=> op_q == sbsp_pkg::SBSP_READ)
    else $error("read command not taken");

  chk_op_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE8
    en && cmd.select && cmd.write |=> op_q == sbsp_pkg::SBSP_WRITE)
    else $error("write command not taken");

  chk_op_desel: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    en && !cmd.select |=> op_q == sbsp_pkg::SBSP_DESEL)
    else $error("deselect not taken");

  chk_first_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    en && was_desel_q && cmd.select |=> first_q)
    else $error("first cycle after deselect not marked");

  chk_first_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    en && !(was_desel_q && cmd.select) |=> !first_q)
    else $error("first cycle mark stuck");

  // -------------------------------------------------------------
  // Write data capture and commit
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wdata_q <= sbsp_pkg::DATA_RST;
      waddr_q <= sbsp_pkg::ADDR_RST;
      wpend_q <= 1'b0;
    end
    else
    begin
      wpend_q <= 1'b0;
      if (en && op_q == sbsp_pkg::SBSP_WRITE)
      begin
        wdata_q <= dq_i; // RULE8
        waddr_q <= cur_addr;
        wpend_q <= 1'b1;
      end
    end
  end

  // Write path checks
  chk_wpend_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    !en |=> !wpend_q)
    else $error("write committed on an ignored edge");

  chk_waddr_cap: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE8
    en && op_q == sbsp_pkg::SBSP_WRITE |=> waddr_q == $past(cur_addr))
    else $error("write address not captured");

  chk_sleep_nowr: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    sleep_q |=> !wpend_q)
    else $error("write committed while asleep");

  sbsp_mem u_mem
  (
    .mclk_i  (mclk_i),
    .wr_i    (wpend_q),
    .widx_i  (to_idx(waddr_q)),
    .wdata_i (wdata_q),
    .ridx_i  (to_idx(cur_addr)),
    .rdata_o (rdata)
  );

  // -------------------------------------------------------------
  // Read output register and drive control
  // -------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dq_q <= sbsp_pkg::DATA_RST;
    else if (en && op_q == sbsp_pkg::SBSP_READ)
      dq_q <= (wpend_q && waddr_q == cur_addr) ? wdata_q : rdata; // RULE9
  end

  assign masked  = op_q != sbsp_pkg::SBSP_READ || first_q; // RULE7
  assign dq_oe_o = !out_en_n_i && !masked && !sleep_q; // RULE6 RULE7
  assign dq_o    = dq_q;

  chk_gate_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    clock_gate_n_i && !sleep_q |=> op_q == $past(op_q)) // RULE5
    else $error("operation changed while clock gated");
  chk_desel_float: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    op_q == sbsp_pkg::SBSP_DESEL |-> !dq_oe_o) // RULE7
    else $error("driving while deselected");
  chk_write_float: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    op_q == sbsp_pkg::SBSP_WRITE |-> !dq_oe_o) // RULE7
    else $error("driving during write data");
  chk_oe_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    out_en_n_i |-> !dq_oe_o) // RULE6
    else $error("driving with output enable high");
  chk_wdata_cap: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE8
    en && op_q == sbsp_pkg::SBSP_WRITE |=> wpend_q && wdata_q == $past(dq_i))
    else $error("write data not captured");
  chk_sleep_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sleep_q |=> op_q == sbsp_pkg::SBSP_DESEL) // RULE11
    else $error("active while asleep");

  // Read path checks
  chk_read_word: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    en && op_q == sbsp_pkg::SBSP_READ && !(wpend_q && waddr_q == cur_addr)
      |=> dq_q == $past(rdata))
    else $error("read word not registered");

  chk_read_fwd: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    en && op_q == sbsp_pkg::SBSP_READ && wpend_q && waddr_q == cur_addr
      |=> dq_q == $past(wdata_q))
    else $error("pending write not forwarded");

  chk_dq_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    !(en && op_q == sbsp_pkg::SBSP_READ) |=> $stable(dq_q))
    else $error("read data changed outside a read");

  chk_first_float: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    first_q |-> !dq_oe_o)
    else $error("driving in first cycle after deselect");

  chk_read_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE6
    op_q == sbsp_pkg::SBSP_READ && !first_q && !out_en_n_i && !sleep_q
      |-> dq_oe_o)
    else $error("not driving a read with output enable low");

  chk_sleep_float: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    sleep_q |-> !dq_oe_o)
    else $error("driving while asleep");

  // -------------------------------------------------------------
  // Stretch monitor
  // -------------------------------------------------------------
  // Counts ignored edges, saturating
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stretch_q <= 4'h0;
    else if (en)
      stretch_q <= 4'h0;
    else if (stretch_q != 4'hF)
      stretch_q <= stretch_q + 4'h1;
  end

  chk_stretch_dq: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE5
    stretch_q != 4'h0 |-> $stable(dq_q))
    else $error("read data changed while stretched");

  chk_stretch_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE5
    stretch_q != 4'h0 |-> $stable(cur_addr))
    else $error("address changed while stretched");

  chk_stretch_wdat: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE5
    stretch_q != 4'h0 |-> $stable(wdata_q))
    else $error("write data changed while stretched");
endmodule
`default_nettype wire

// >>> sbsp_port_tb_top.sv
// Self-checking testbench of the burst memory port
`default_nettype none
`timescale 1ns/10ps
module sbsp_port_tb_top;
  logic                        mclk_i     = 1'b0;
  logic                        rst_n_i    = 1'b0;
  logic                        oe_n       = 1'b0;
  logic                        gate_n;
  logic                        slp;
  logic                        oe;
  logic                        asl;
  sbsp_pkg::sbsp_cmd_t         cmd;
  logic [sbsp_pkg::DATA_W-1:0] wd;
  logic [sbsp_pkg::DATA_W-1:0] rd;
  int                          errors     = 0;
  int                          n_compared = 0;

  always #5 mclk_i = ~mclk_i;

  sbsp_ctrl_model m (.mclk_i(mclk_i), .clock_gate_n_o(gate_n),
    .cmd_o(cmd), .sleep_request_o(slp), .dq_o(wd));

  sbsp_port dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .clock_gate_n_i(gate_n), .select_i(cmd.select),
    .write_n_i(~cmd.write), .advance_or_load_i(cmd.advance_or_load),
    .addr_i(cmd.addr), .sleep_request_i(slp), .out_en_n_i(oe_n),
    .dq_i(wd), .dq_o(rd), .dq_oe_o(oe), .asleep_o(asl));

  function automatic logic [39:0] pat(input int i);
    return {5{i[7:0]}} ^ 40'hC35A96F00F;
  endfunction

  task automatic cmp(input logic [39:0] g, input logic [39:0] e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input int ad);
    m.step(0, 1, 1, 0, ad[20:0], 0, 0);
    m.step(0, 0, 0, 0, 0, 1, pat(ad));
    #1 cmp(oe, 0);
  endtask

  task automatic t_reset();
    #1 cmp(oe, 0);
    cmp(asl, 0);
    cmp(rd, sbsp_pkg::DATA_RST);
    $display("test reset done");
  endtask

  task automatic t_burst();
    for (int i = 8; i < 12; i++)
      wr(i);
    for (int i = 0; i < 6; i++)
    begin
      m.step(0, i < 4, 0, i > 0, 21'h00000A, 0, 0);
      #1;
      if (i >= 2)
        cmp(rd, pat(8 + i % 4));
      if (i == 1)
        cmp(oe, 0);
      if (i == 3)
      begin
        cmp(oe, 1);
        oe_n <= 1'b1;
        #1 cmp(oe, 0);
        oe_n <= 1'b0;
      end
      if (i == 5)
        cmp(oe, 0);
    end
    $display("test burst done");
  endtask

  task automatic t_gate();
    m.step(0, 1, 0, 0, 21'h00000A, 0, 0);
    m.step(0, 1, 0, 0, 21'h00000A, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      m.step(1, 1, 0, 0, 21'h00000B, 0, 0);
      #1 cmp(rd, pat(10));
    end
    for (int i = 0; i < 2; i++)
    begin
      m.step(0, 0, 0, 0, 0, 0, 0);
      #1 cmp(rd, pat(10));
    end
    $display("test gate done");
  endtask

  task automatic t_sleep();
    m.nap(1'b1);
    m.step(0, 0, 0, 0, 0, 0, 0);
    m.step(0, 0, 0, 0, 0, 1, 40'h0);
    #1 cmp(asl, 1);
    m.nap(1'b0);
    m.step(0, 0, 0, 0, 0, 0, 0);
    m.step(0, 1, 0, 0, 21'h000009, 0, 0);
    m.step(0, 0, 0, 0, 0, 0, 0);
    m.step(0, 0, 0, 0, 0, 0, 0);
    #1 cmp(asl, 0);
    cmp(rd, pat(9));
    $display("test sleep done");
  endtask

  task automatic t_rerun();
    @(posedge mclk_i) rst_n_i <= 1'b0;
    #1 cmp(rd, sbsp_pkg::DATA_RST);
    cmp(oe, 0);
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    m.step(0, 1, 0, 0, 21'h000009, 0, 0);
    m.step(0, 0, 0, 0, 0, 0, 0);
    m.step(0, 0, 0, 0, 0, 0, 0);
    #1 cmp(rd, pat(9));
    $display("test rerun done");
  endtask

  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_burst();
    t_gate();
    t_sleep();
    t_rerun();
    conclude();
  end

  initial
  begin
    #20000;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
